// ### rtl/pae_alarm_eval.sv
// Process alarm evaluator: four alarm channels with type select, deviation,
// absolute, set point and manipulated variable alarms, hysteresis and
// standby sequence, routed to auxiliary and control outputs.
// Assumes the measurement loop runs on clk and pulses sample_tick once per
// sampling cycle with valid process_value, set_point and MV inputs.
//
// Behaviour
// - Each alarm drives an aux output; control outputs may be assigned alarm 1..4.
// - Alarm state depends on type, alarm value, hysteresis and standby sequence.
// - Each channel has own type; code 0 keeps output off; reset type 2.
// - Loop burnout type 12 accepted only on channel 1, rejected elsewhere.
// - With heater fault detection, aux 1 carries heater alarm; alarm 1 disabled unless a control output selects it.
// - Type 1: on when process value outside set point band, limits independent.
// - Type 2: on when process value at least alarm value above set point.
// - Type 3: on when process value at least alarm value below set point.
// - Type 4: on when process value inside band around set point.
// - Types 1 and 4 use separate upper and lower deviation settings.
// - Type 5 is type 1 with standby sequence.
// - Type 6 is type 2 with standby sequence.
// - Type 7 is type 3 with standby sequence.
// - Type 8: on when process value above alarm value.
// - Type 9: on when process value below alarm value.
// - Types 10 and 11 are types 8 and 9 with standby sequence.
// - Type 13 selects the change rate alarm for the channel.
// - Type 14: on when set point above alarm value.
// - Type 15: on when set point below alarm value.
// - Type 16: on when manipulated variable above alarm value.
// - Standby suppresses alarm until value leaves alarm region then re-enters.
// - Heating/cooling: MV high checks heating output, MV low checks cooling.
// - Each channel uses its own hysteresis.
`timescale 1ns/1ps
module pae_alarm_eval import pae_pkg::*; #(
   parameter int W = 16
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic sample_tick,
   input wire logic [W-1:0] process_value,
   input wire logic [W-1:0] set_point,
   input wire logic [W-1:0] manipulated_variable,
   input wire logic [W-1:0] manipulated_variable_cool,
   input wire logic heater_fault_detection_fitted,
   input wire logic heater_alarm_in,
   input wire logic loop_burnout_alarm_in,
   input wire logic [NUM_CH-1:0] rate_alarm_in,
   input wire logic control_drive1,
   input wire logic control_drive2,
   output logic [NUM_CH-1:0] aux_out,
   output logic ctrl_out1,
   output logic ctrl_out2
);
   localparam int XW = W + 2;

   // ------------------------------------------------------------
   // State
   // ------------------------------------------------------------
   logic hreadyout_reg, hresp_reg;
   logic [31:0] hrdata_reg;
   logic acc_wr_reg;
   logic [7:0] acc_addr_reg;
   logic hc_mode_reg;
   logic [TYPE_W-1:0] type_reg [NUM_CH];
   logic [W-1:0] value_reg [NUM_CH];
   logic [W-1:0] upper_reg [NUM_CH];
   logic [W-1:0] lower_reg [NUM_CH];
   logic [W-1:0] hyst_reg [NUM_CH];
   logic [SEL_W-1:0] sel1_reg, sel2_reg;
   logic aux1_alarm_reg, hfd_reg, started_reg;
   logic [NUM_CH-1:0] alarm_reg, standby_reg;
   logic [NUM_CH-1:0] aux_reg;
   logic ctrl1_reg, ctrl2_reg;
   logic [NUM_CH-1:0] raw_next, has_sb;
   logic [31:0] rd_mux;
   logic wr_ctrl, wr_type, sb_restart, ch1_enabled;
   logic [1:0] acc_ch, rd_ch;
   logic signed [XW-1:0] pv_x, sp_x, mvh_x, mvl_x;
   logic signed [XW-1:0] val_x [NUM_CH];
   logic signed [XW-1:0] up_x [NUM_CH];
   logic signed [XW-1:0] lo_x [NUM_CH];
   logic signed [XW-1:0] hys_x [NUM_CH];

   // Sign-extend to keep set point plus deviation free of overflow
   function automatic logic signed [XW-1:0] sx(input logic [W-1:0] v);
      return signed'({{2{v[W-1]}}, v});
   endfunction

   // Upper comparison; once on, holds until a drops hysteresis below t
   function automatic logic over(input logic signed [XW-1:0] a,
         input logic signed [XW-1:0] t, input logic signed [XW-1:0] h,
         input logic st, input logic incl);
      logic r;
      r = 1'b0;
      if (st) begin
         r = (a > t - h);
      end else begin
         r = incl ? (a >= t) : (a > t);
      end
      return r;
   endfunction

   // Lower comparison, mirror image of over()
   function automatic logic under(input logic signed [XW-1:0] a,
         input logic signed [XW-1:0] t, input logic signed [XW-1:0] h,
         input logic st, input logic incl);
      logic r;
      r = 1'b0;
      if (st) begin
         r = (a < t + h);
      end else begin
         r = incl ? (a <= t) : (a < t);
      end
      return r;
   endfunction

   // ------------------------------------------------------------
   // AHB-Lite slave: zero wait states, read data latched in address phase
   // ------------------------------------------------------------
   // Reads are prepared from the address phase so hrdata comes from a flop;
   // a read issued in the data phase of a write would see the old value.
   always_ff @(posedge clk) begin
      if (srst) begin
         hreadyout_reg <= 1'b1;
         hresp_reg <= 1'b0;
         hrdata_reg <= 32'h0000_0000;
         acc_wr_reg <= 1'b0;
         acc_addr_reg <= 8'h00;
      end else begin
         hreadyout_reg <= 1'b1;
         hresp_reg <= 1'b0; // Always OKAY, unmapped included
         acc_wr_reg <= hsel && htrans[1] && hready && hwrite;
         if (hsel && htrans[1] && hready) begin
            acc_addr_reg <= haddr[7:0];
            hrdata_reg <= hwrite ? 32'h0000_0000 : rd_mux;
         end
      end
   end

   // Read decode; unmapped words read as zero
   assign rd_ch = 2'((haddr[7:0] - OFS_CH_BASE) >> CH_SHIFT);
   always_comb begin
      rd_mux = 32'h0000_0000;
      if (haddr[7:0] == OFS_CTRL) begin
         rd_mux[CTRL_HC_BIT] = hc_mode_reg;
      end else if (haddr[7:0] == OFS_TYPE) begin
         for (int n = 0; n < NUM_CH; n++) begin
            rd_mux[n*TYPE_W +: TYPE_W] = type_reg[n];
         end
      end else if (haddr[7:0] == OFS_ASSIGN) begin
         rd_mux[ASG_C1_LSB +: SEL_W] = sel1_reg;
         rd_mux[ASG_C2_LSB +: SEL_W] = sel2_reg;
         rd_mux[ASG_AUX1_BIT] = aux1_alarm_reg;
      end else if (haddr[7:0] == OFS_STATUS) begin
         rd_mux[NUM_CH-1:0] = alarm_reg;
         rd_mux[STAT_SB_LSB +: NUM_CH] = standby_reg;
      end else if (haddr[7:0] >= OFS_CH_BASE && haddr[7:0] < OFS_CH_END) begin
         unique case (haddr[3:2])
            SUB_VALUE: rd_mux[W-1:0] = value_reg[rd_ch];
            SUB_UPPER: rd_mux[W-1:0] = upper_reg[rd_ch];
            SUB_LOWER: rd_mux[W-1:0] = lower_reg[rd_ch];
            SUB_HYST: rd_mux[W-1:0] = hyst_reg[rd_ch];
         endcase
      end
   end

   // Write strobes in the data phase
   assign acc_ch = 2'((acc_addr_reg - OFS_CH_BASE) >> CH_SHIFT);
   assign wr_ctrl = acc_wr_reg && (acc_addr_reg == OFS_CTRL);
   assign wr_type = acc_wr_reg && (acc_addr_reg == OFS_TYPE);
   assign sb_restart = wr_ctrl && hwdata[CTRL_SBRST_BIT];

   // ------------------------------------------------------------
   // Configuration registers
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         hc_mode_reg <= 1'b0;
         for (int n = 0; n < NUM_CH; n++) begin
            type_reg[n] <= TYPE_RST;
         end
      end else begin
         if (wr_ctrl) begin
            hc_mode_reg <= hwdata[CTRL_HC_BIT];
         end
         // Out-of-range codes and burnout on channels 2..4 leave the field as is
         if (wr_type) begin
            for (int n = 0; n < NUM_CH; n++) begin
               if (hwdata[n*TYPE_W +: TYPE_W] <= T_MAX &&
                     !(n != 0 && hwdata[n*TYPE_W +: TYPE_W] == T_LOOP_BURNOUT)) begin
                  type_reg[n] <= hwdata[n*TYPE_W +: TYPE_W];
               end
            end
         end
      end
   end

   // Per-channel values: alarm value, upper and lower deviation, hysteresis
   always_ff @(posedge clk) begin
      if (srst) begin
         for (int n = 0; n < NUM_CH; n++) begin
            value_reg[n] <= VALUE_RST[W-1:0];
            upper_reg[n] <= DEV_RST[W-1:0];
            lower_reg[n] <= DEV_RST[W-1:0];
            hyst_reg[n] <= HYST_RST[W-1:0];
         end
      end else if (acc_wr_reg && acc_addr_reg >= OFS_CH_BASE && acc_addr_reg < OFS_CH_END) begin
         unique case (acc_addr_reg[3:2])
            SUB_VALUE: value_reg[acc_ch] <= hwdata[W-1:0];
            SUB_UPPER: upper_reg[acc_ch] <= hwdata[W-1:0];
            SUB_LOWER: lower_reg[acc_ch] <= hwdata[W-1:0];
            SUB_HYST: hyst_reg[acc_ch] <= hwdata[W-1:0];
         endcase
      end
   end

   // Output assignment; heater fault strap is caught just after reset release
   always_ff @(posedge clk) begin
      if (srst) begin
         sel1_reg <= SEL_NONE;
         sel2_reg <= SEL_NONE;
         aux1_alarm_reg <= 1'b1;
         hfd_reg <= 1'b0;
         started_reg <= 1'b0;
      end else begin
         if (!started_reg) begin
            started_reg <= 1'b1;
            hfd_reg <= heater_fault_detection_fitted;
            aux1_alarm_reg <= !heater_fault_detection_fitted;
         end else if (acc_wr_reg && acc_addr_reg == OFS_ASSIGN) begin
            if (hwdata[ASG_C1_LSB +: SEL_W] <= SEL_MAX) begin
               sel1_reg <= hwdata[ASG_C1_LSB +: SEL_W];
            end
            if (hwdata[ASG_C2_LSB +: SEL_W] <= SEL_MAX) begin
               sel2_reg <= hwdata[ASG_C2_LSB +: SEL_W];
            end
            aux1_alarm_reg <= hwdata[ASG_AUX1_BIT];
         end
      end
   end

   // Alarm 1 runs only when no heater alarm owns it or an output selects it
   assign ch1_enabled = !hfd_reg || aux1_alarm_reg || sel1_reg == 3'h1 ||
      sel2_reg == 3'h1;

   // ------------------------------------------------------------
   // Evaluation
   // ------------------------------------------------------------
   assign pv_x = sx(process_value);
   assign sp_x = sx(set_point);
   // Heating/cooling splits the MV alarms between the two outputs
   assign mvh_x = sx(manipulated_variable);
   assign mvl_x = hc_mode_reg ? sx(manipulated_variable_cool) : mvh_x;

   always_comb begin
      for (int n = 0; n < NUM_CH; n++) begin
         val_x[n] = sx(value_reg[n]);
         up_x[n] = sp_x + sx(upper_reg[n]);
         lo_x[n] = sp_x - sx(lower_reg[n]);
         hys_x[n] = sx(hyst_reg[n]);
      end
   end

   // Raw condition per channel, with hysteresis from the current state
   always_comb begin
      for (int n = 0; n < NUM_CH; n++) begin
         raw_next[n] = 1'b0;
         has_sb[n] = 1'b0;
         unique case (type_reg[n])
            T_BAND_OUT, T_BAND_OUT_SB: begin
               raw_next[n] = over(pv_x, up_x[n], hys_x[n], alarm_reg[n], 1'b0) ||
                  under(pv_x, lo_x[n], hys_x[n], alarm_reg[n], 1'b0);
               has_sb[n] = (type_reg[n] == T_BAND_OUT_SB);
            end
            T_BAND_IN: begin
               raw_next[n] = under(pv_x, up_x[n], hys_x[n], alarm_reg[n], 1'b1) &&
                  over(pv_x, lo_x[n], hys_x[n], alarm_reg[n], 1'b1);
            end
            T_DEV_HI, T_DEV_HI_SB: begin
               raw_next[n] = over(pv_x, sp_x + val_x[n], hys_x[n], alarm_reg[n], 1'b1);
               has_sb[n] = (type_reg[n] == T_DEV_HI_SB);
            end
            T_DEV_LO, T_DEV_LO_SB: begin
               raw_next[n] = under(pv_x, sp_x - val_x[n], hys_x[n], alarm_reg[n], 1'b1);
               has_sb[n] = (type_reg[n] == T_DEV_LO_SB);
            end
            T_ABS_HI, T_ABS_HI_SB: begin
               raw_next[n] = over(pv_x, val_x[n], hys_x[n], alarm_reg[n], 1'b0);
               has_sb[n] = (type_reg[n] == T_ABS_HI_SB);
            end
            T_ABS_LO, T_ABS_LO_SB: begin
               raw_next[n] = under(pv_x, val_x[n], hys_x[n], alarm_reg[n], 1'b0);
               has_sb[n] = (type_reg[n] == T_ABS_LO_SB);
            end
            T_LOOP_BURNOUT: raw_next[n] = loop_burnout_alarm_in;
            T_RATE: raw_next[n] = rate_alarm_in[n];
            T_SP_HI: raw_next[n] = over(sp_x, val_x[n], hys_x[n], alarm_reg[n], 1'b0);
            T_SP_LO: raw_next[n] = under(sp_x, val_x[n], hys_x[n], alarm_reg[n], 1'b0);
            T_MV_HI: raw_next[n] = over(mvh_x, val_x[n], hys_x[n], alarm_reg[n], 1'b0);
            T_MV_LO: raw_next[n] = under(mvl_x, val_x[n], hys_x[n], alarm_reg[n], 1'b0);
            default: raw_next[n] = 1'b0; // Type 0 and illegal codes stay off
         endcase
      end
   end

   // Alarm state moves only on a sampling tick, so all channels see one sample
   always_ff @(posedge clk) begin
      if (srst) begin
         alarm_reg <= '0;
      end else if (sample_tick) begin
         for (int n = 0; n < NUM_CH; n++) begin
            if (n == 0 && !ch1_enabled) begin
               alarm_reg[n] <= 1'b0;
            end else if (has_sb[n] && standby_reg[n]) begin
               alarm_reg[n] <= 1'b0;
            end else begin
               alarm_reg[n] <= raw_next[n];
            end
         end
      end
   end

   // Standby pending: armed at reset, on type change and on restart request,
   // cleared once the value has been outside the alarm region
   always_ff @(posedge clk) begin
      if (srst) begin
         standby_reg <= '1;
      end else if (wr_type || sb_restart) begin
         standby_reg <= '1;
      end else if (sample_tick) begin
         for (int n = 0; n < NUM_CH; n++) begin
            if (has_sb[n] && !raw_next[n]) begin
               standby_reg[n] <= 1'b0;
            end
         end
      end
   end

   // ------------------------------------------------------------
   // Output routing
   // ------------------------------------------------------------
   always_ff @(posedge clk) begin
      if (srst) begin
         aux_reg <= '0;
         ctrl1_reg <= 1'b0;
         ctrl2_reg <= 1'b0;
      end else begin
         aux_reg <= alarm_reg;
         if (!aux1_alarm_reg) begin
            aux_reg[0] <= heater_alarm_in;
         end
         ctrl1_reg <= (sel1_reg == SEL_NONE) ? control_drive1 :
            alarm_reg[2'(sel1_reg - 3'h1)];
         ctrl2_reg <= (sel2_reg == SEL_NONE) ? control_drive2 :
            alarm_reg[2'(sel2_reg - 3'h1)];
      end
   end

   assign hreadyout = hreadyout_reg;
   assign hresp = hresp_reg;
   assign hrdata = hrdata_reg;
   assign aux_out = aux_reg;
   assign ctrl_out1 = ctrl1_reg;
   assign ctrl_out2 = ctrl2_reg;

   // ------------------------------------------------------------
   // Assertions
   // ------------------------------------------------------------
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);

   a_type_zero_off: assert property (
      sample_tick && type_reg[1] == T_OFF |=> !alarm_reg[1])
      else $error("Channel 2 alarm on with type off");
   a_burnout_ch1_only: assert property (
      wr_type && hwdata[TYPE_W +: TYPE_W] == T_LOOP_BURNOUT |=> type_reg[1] != T_LOOP_BURNOUT)
      else $error("Burnout type taken on channel 2");
   a_aux_follows: assert property (
      1'b1 |=> aux_out[2] == $past(alarm_reg[2]))
      else $error("Aux output 3 does not follow alarm 3");
   a_ctrl_assigned: assert property (
      sel1_reg == 3'h2 ##1 sel1_reg == 3'h2 |-> ctrl_out1 == $past(alarm_reg[1]))
      else $error("Control output 1 misses alarm 2");
   a_dev_high_on: assert property (
      sample_tick && type_reg[1] == T_DEV_HI && pv_x >= sp_x + val_x[1] |=> alarm_reg[1])
      else $error("Upper deviation alarm not raised");
   a_abs_low_on: assert property (
      sample_tick && type_reg[2] == T_ABS_LO && pv_x < val_x[2] |=> alarm_reg[2])
      else $error("Absolute low alarm not raised");
   a_standby_hold: assert property (
      sample_tick && has_sb[3] && standby_reg[3] |=> !alarm_reg[3])
      else $error("Alarm raised during standby");
   a_hyst_hold: assert property (
      sample_tick && type_reg[1] == T_ABS_HI && alarm_reg[1] && pv_x > val_x[1] - hys_x[1]
      |=> alarm_reg[1])
      else $error("Alarm dropped inside hysteresis");
   a_tick_only: assert property (
      !sample_tick |=> $stable(alarm_reg))
      else $error("Alarm changed without sampling tick");
   a_heater_aux: assert property (
      !aux1_alarm_reg ##1 !aux1_alarm_reg |-> aux_out[0] == $past(heater_alarm_in))
      else $error("Aux output 1 misses heater alarm");

   c_dev_alarm: cover property (sample_tick && type_reg[1] == T_DEV_HI ##1 alarm_reg[1]);
   c_standby_done: cover property (standby_reg[3] && has_sb[3] ##[1:50] alarm_reg[3]);
   c_ctrl_alarm: cover property (sel2_reg != SEL_NONE && ctrl_out2);
endmodule

// ### common/pae_pkg.sv
// Constants for the process alarm evaluator: register map, field layout,
// alarm type codes and reset values.
// Assumes a 32-bit AHB-Lite register bus and four alarm channels.
package pae_pkg;
   // ------------------------------------------------------------
   // Register map (byte addresses, low eight address bits)
   // ------------------------------------------------------------
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_TYPE = 8'h04;
   localparam logic [7:0] OFS_ASSIGN = 8'h08;
   localparam logic [7:0] OFS_STATUS = 8'h0c;
   localparam logic [7:0] OFS_CH_BASE = 8'h10; // Four words per channel
   localparam logic [7:0] OFS_CH_END = 8'h50;
   localparam int CH_SHIFT = 4;                // Channel index from address
   localparam logic [1:0] SUB_VALUE = 2'h0;
   localparam logic [1:0] SUB_UPPER = 2'h1;
   localparam logic [1:0] SUB_LOWER = 2'h2;
   localparam logic [1:0] SUB_HYST = 2'h3;
   localparam int NUM_CH = 4;

   // ------------------------------------------------------------
   // Field layout
   // ------------------------------------------------------------
   localparam int CTRL_HC_BIT = 0;     // Heating/cooling control mode
   localparam int CTRL_SBRST_BIT = 1;  // Write 1: restart standby sequences
   localparam int TYPE_W = 5;          // One type field per channel
   localparam int SEL_W = 3;           // Control output assignment field
   localparam int ASG_C1_LSB = 0;
   localparam int ASG_C2_LSB = 4;
   localparam int ASG_AUX1_BIT = 8;    // 1: aux output 1 carries alarm 1
   localparam int STAT_SB_LSB = 4;     // Standby pending flags
   localparam logic [SEL_W-1:0] SEL_NONE = 3'h0; // Output keeps control drive
   localparam logic [SEL_W-1:0] SEL_MAX = 3'h4;

   // ------------------------------------------------------------
   // Alarm type codes
   // ------------------------------------------------------------
   localparam logic [TYPE_W-1:0] T_OFF = 5'h00;
   localparam logic [TYPE_W-1:0] T_BAND_OUT = 5'h01;
   localparam logic [TYPE_W-1:0] T_DEV_HI = 5'h02;
   localparam logic [TYPE_W-1:0] T_DEV_LO = 5'h03;
   localparam logic [TYPE_W-1:0] T_BAND_IN = 5'h04;
   localparam logic [TYPE_W-1:0] T_BAND_OUT_SB = 5'h05;
   localparam logic [TYPE_W-1:0] T_DEV_HI_SB = 5'h06;
   localparam logic [TYPE_W-1:0] T_DEV_LO_SB = 5'h07;
   localparam logic [TYPE_W-1:0] T_ABS_HI = 5'h08;
   localparam logic [TYPE_W-1:0] T_ABS_LO = 5'h09;
   localparam logic [TYPE_W-1:0] T_ABS_HI_SB = 5'h0a;
   localparam logic [TYPE_W-1:0] T_ABS_LO_SB = 5'h0b;
   localparam logic [TYPE_W-1:0] T_LOOP_BURNOUT = 5'h0c;
   localparam logic [TYPE_W-1:0] T_RATE = 5'h0d;
   localparam logic [TYPE_W-1:0] T_SP_HI = 5'h0e;
   localparam logic [TYPE_W-1:0] T_SP_LO = 5'h0f;
   localparam logic [TYPE_W-1:0] T_MV_HI = 5'h10;
   localparam logic [TYPE_W-1:0] T_MV_LO = 5'h11;
   localparam logic [TYPE_W-1:0] T_MAX = 5'h11;
   localparam logic [TYPE_W-1:0] TYPE_RST = T_DEV_HI;

   // ------------------------------------------------------------
   // Reset values
   // ------------------------------------------------------------
   localparam logic [15:0] VALUE_RST = 16'h000a;
   localparam logic [15:0] DEV_RST = 16'h0000;
   localparam logic [15:0] HYST_RST = 16'h0002;
endpackage

// ### verif/pae_loop_model.sv
// Model of the measurement loop that feeds the alarm evaluator.
// Assumes the bench calls sample just after a rising clock edge.
`timescale 1ns/1ps
module pae_loop_model (
   input wire logic clk,
   output logic tick,
   output logic [15:0] pv,
   output logic [15:0] sp,
   output logic [15:0] mv
);
   // Idle values until the first sampling cycle
   initial begin
      tick = 1'b0;
      pv = 16'h0000;
      sp = 16'h0000;
      mv = 16'h0000;
   end

   // One sampling cycle: one-cycle tick with that cycle's values
   task automatic sample(input logic [15:0] p, input logic [15:0] s, input logic [15:0] m);
      tick <= 1'b1;
      pv <= p;
      sp <= s;
      mv <= m;
      @(posedge clk);
      tick <= 1'b0;
   endtask
endmodule

// ### verif/tb_pae_alarm_eval.sv
// Self-checking bench: bus reads/writes and sampling cycles on channel 1.
// Assumes zero-wait AHB-Lite slave and outputs one edge after STATUS.
`timescale 1ns/1ps
module tb_pae_alarm_eval import pae_pkg::*;;
   logic clk, srst, hsel, hwrite, hrdy, hresp, c1, c2, tick;
   logic [31:0] haddr, hwdata, hrdata, d;
   logic [1:0] htrans;
   logic [3:0] aux;
   logic [7:0] ext;
   logic [15:0] pv, sp, mv;
   logic [4:0] cur;
   int n_fail, samples_checked;

   // ---------------------------------------------
   // Design and loop model
   // ---------------------------------------------
   pae_alarm_eval pae_alarm_eval_inst (.clk(clk), .srst(srst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hrdy),
      .hreadyout(hrdy), .hresp(hresp), .hrdata(hrdata), .sample_tick(tick),
      .process_value(pv), .set_point(sp), .manipulated_variable(mv),
      .manipulated_variable_cool(16'h0000), .heater_fault_detection_fitted(1'b0),
      .heater_alarm_in(ext[0]), .loop_burnout_alarm_in(ext[1]), .rate_alarm_in(ext[5:2]),
      .control_drive1(ext[6]), .control_drive2(ext[7]), .aux_out(aux), .ctrl_out1(c1),
      .ctrl_out2(c2));
   pae_loop_model pae_loop_model_inst (.clk(clk), .tick(tick), .pv(pv), .sp(sp), .mv(mv));

   // ---------------------------------------------
   // Bus tasks and checks
   // ---------------------------------------------
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] wd);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      @(posedge clk);
      while (hrdy !== 1'b1) @(posedge clk);
      d = hrdata;
   endtask

   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      samples_checked++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask

   // One sampling cycle on channel 1; TYPE rewritten only on a change
   task automatic ty(input logic [4:0] t, input logic [15:0] p, input logic [15:0] s,
      input logic [15:0] m, input logic e);
      if (t !== cur) begin
         // Same code on all four channels so the channel 2..4 assertions see it
         xfer(OFS_TYPE, 1'b1, {12'h000, t, t, t, t});
         cur = t;
      end
      pae_loop_model_inst.sample(p, s, m);
      @(posedge clk);
      #1;
      cmp({31'h0, aux[0]}, {31'h0, e});
      cmp({31'h0, c1}, {31'h0, e});
      cmp({31'h0, c2}, 32'h1);
      cmp({31'h0, hresp}, 32'h0);
      xfer(OFS_STATUS, 1'b0, 32'h0);
      cmp({31'h0, d[0]}, {31'h0, e});
      $display("case type %0d done", t);
   endtask

   task automatic give_verdict;
      $display("checked %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask

   // ---------------------------------------------
   // Clock, watchdog and test sequence
   // ---------------------------------------------
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // Whole run needs well under 2000 cycles
   initial begin
      repeat (20000) @(posedge clk);
      n_fail++;
      give_verdict;
   end

   initial begin
      n_fail = 0;
      samples_checked = 0;
      srst = 1'b1;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      ext = 8'hbe; // Burnout and rate alarms high, drive 2 high
      cur = T_DEV_HI;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      @(posedge clk);
      xfer(OFS_TYPE, 1'b0, 32'h0);
      cmp(d, 32'h00010842);
      xfer(8'h10, 1'b0, 32'h0);
      cmp(d, 32'h0000000a);
      xfer(8'h1c, 1'b0, 32'h0);
      cmp(d, 32'h00000002);
      xfer(8'h60, 1'b0, 32'h0);
      cmp(d, 32'h0);
      cmp({28'h0, aux}, 32'h0);
      xfer(OFS_TYPE, 1'b1, 32'h00010982); // Burnout code on channel 2
      xfer(OFS_TYPE, 1'b0, 32'h0);
      cmp(d, 32'h00010842);
      xfer(OFS_ASSIGN, 1'b1, 32'h00000101);
      xfer(8'h14, 1'b1, 32'h5);
      xfer(8'h18, 1'b1, 32'h5);
      ty(5'd2, 16'd110, 16'd100, 16'd0, 1'b1);
      ty(5'd2, 16'd109, 16'd100, 16'd0, 1'b1);
      ty(5'd2, 16'd108, 16'd100, 16'd0, 1'b0);
      ty(5'd3, 16'd90, 16'd100, 16'd0, 1'b1);
      ty(5'd0, 16'd90, 16'd100, 16'd0, 1'b0);
      ty(5'd8, 16'd11, 16'd0, 16'd0, 1'b1);
      ty(5'd8, 16'd9, 16'd0, 16'd0, 1'b1);
      ty(5'd9, 16'd5, 16'd0, 16'd0, 1'b1);
      ty(5'd14, 16'd0, 16'd11, 16'd0, 1'b1);
      ty(5'd15, 16'd0, 16'd5, 16'd0, 1'b1);
      ty(5'd16, 16'd0, 16'd0, 16'd11, 1'b1);
      ty(5'd16, 16'd0, 16'd0, 16'd5, 1'b0);
      ty(5'd1, 16'd106, 16'd100, 16'd0, 1'b1);
      ty(5'd4, 16'd100, 16'd100, 16'd0, 1'b1);
      ty(5'd4, 16'd110, 16'd100, 16'd0, 1'b0);
      ty(5'd12, 16'd0, 16'd0, 16'd0, 1'b1);
      ty(5'd13, 16'd0, 16'd0, 16'd0, 1'b1);
      ty(5'd6, 16'd200, 16'd100, 16'd0, 1'b0);
      ty(5'd6, 16'd100, 16'd100, 16'd0, 1'b0);
      ty(5'd6, 16'd110, 16'd100, 16'd0, 1'b1);
      give_verdict;
   end
endmodule
